/* include/bpdma_map.svh */
// Purpose: constants for the backplane dma bus interface
// Assumes: 16-bit multiplexed bus, 20 MHz clock
// Notes: bus pins are low-true at the pins; ends use active-high internally
`ifndef BPDMA_MAP_SVH
`define BPDMA_MAP_SVH
`define BPDMA_AW 16
`define BPDMA_BANK7_BASE 16'hF000
`define BPDMA_CSR_ADDR 16'hFF40
`define BPDMA_DATA_ADDR 16'hFF42
`define BPDMA_VECTOR 16'h0070
`define BPDMA_FIFO_DEPTH 32
`endif

/* include/bpdma_pkg.sv */
// Purpose: shared types for the backplane dma bus interface
// Assumes: bpdma_map.svh constants
// Notes: one-hot state codes written out
`default_nettype none
package bpdma_pkg;
  typedef enum logic [6:0] {
    BD_IDLE = 7'h01,
    BD_REQ = 7'h02,
    BD_ADDR = 7'h04,
    BD_DATA = 7'h08,
    BD_WREL = 7'h10,
    BD_SEND = 7'h20,
    BD_VEC = 7'h40
  } bpdma_dev_st_t;
  typedef enum logic [5:0] {
    BH_IDLE = 6'h01,
    BH_ADDR = 6'h02,
    BH_STRB = 6'h04,
    BH_REL = 6'h08,
    BH_END = 6'h10,
    BH_IACK = 6'h20
  } bpdma_host_st_t;
endpackage
`default_nettype wire

/* include/bpdma_bus_if.sv */
// Purpose: backplane bus between tape-side device end and host end
// Assumes: every pin low-true, open-drain (wired-or of asserted lows)
// Notes: oe low means the party drives the pin low (asserted)
`default_nettype none
interface bpdma_bus_if;
  // dev drives: oe_n low asserts; host likewise
  logic [15:0] dal_dev_o, dal_host_o;
  logic dal_dev_oe_n, dal_host_oe_n;
  logic sync_dev_oe_n, sync_host_oe_n;
  logic din_dev_oe_n, din_host_oe_n;
  logic dout_dev_oe_n, dout_host_oe_n;
  logic wtbt_dev_oe_n, wtbt_host_oe_n;
  logic bs7_dev_oe_n, bs7_host_oe_n;
  logic rply_dev_oe_n, rply_host_oe_n;
  logic dmr_oe_n, sack_oe_n, irq_oe_n;
  logic dmgi_n, dmgo_n, iaki_n, iako_n, init_n;
  // resolved low-true levels
  logic [15:0] dal_n;
  logic sync_n, din_n, dout_n, wtbt_n, bs7_n, rply_n, dmr_n, sack_n, irq_n;
  assign dal_n = ~((dal_dev_oe_n ? 16'h0000 : dal_dev_o) | (dal_host_oe_n ? 16'h0000 : dal_host_o));
  assign sync_n = sync_dev_oe_n & sync_host_oe_n;
  assign din_n = din_dev_oe_n & din_host_oe_n;
  assign dout_n = dout_dev_oe_n & dout_host_oe_n;
  assign wtbt_n = wtbt_dev_oe_n & wtbt_host_oe_n;
  assign bs7_n = bs7_dev_oe_n & bs7_host_oe_n;
  assign rply_n = rply_dev_oe_n & rply_host_oe_n;
  assign dmr_n = dmr_oe_n;
  assign sack_n = sack_oe_n;
  assign irq_n = irq_oe_n;
  modport dev (
    output dal_dev_o, dal_dev_oe_n, sync_dev_oe_n, din_dev_oe_n, dout_dev_oe_n,
    output wtbt_dev_oe_n, bs7_dev_oe_n, rply_dev_oe_n, dmr_oe_n, sack_oe_n, irq_oe_n, dmgo_n, iako_n,
    input dal_n, sync_n, din_n, dout_n, wtbt_n, bs7_n, rply_n, dmgi_n, iaki_n, init_n
  );
  modport host (
    output dal_host_o, dal_host_oe_n, sync_host_oe_n, din_host_oe_n, dout_host_oe_n,
    output wtbt_host_oe_n, bs7_host_oe_n, rply_host_oe_n, dmgi_n, iaki_n, init_n,
    input dal_n, sync_n, din_n, dout_n, wtbt_n, bs7_n, rply_n, dmr_n, sack_n, irq_n, dmgo_n, iako_n
  );
endinterface
`default_nettype wire

/* hw/bpdma_fifo.sv */
// Purpose: word fifo between tape side and bus side
// Assumes: single clock, synchronous reset
// Notes: depth must be a power of two
`default_nettype none
module bpdma_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic do_wr, do_rd;
  // full when pointers differ only in the wrap bit
  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_valid = (wp_r != rp_r);
  assign out_data = mem[rp_r[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
    if (srst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* hw/bpdma_dev.sv */
// Purpose: device end: slave for command/status, single-word dma master, vectored interrupt
// Assumes: bus pins synchronous to clk; host end keeps its own handshake order
// Notes: tape side sees word streams; the fifo absorbs tape bursts
`include "bpdma_map.svh"
`default_nettype none
// What this block does
// - all bus signals asserted by pulling low
// - assert bank select for top 4K addresses
// - address first, then data on same lines
// - input transfer during sync needs reply
// - input strobe without sync means interrupt acknowledge
// - block grant while requesting, else pass
// - one bus transfer per dma request
// - on grant assert select-ack, drop request
// - release bus by negating select-ack
// - fetch for tape write, store tape reads
// - never combined read-modify-write cycles
// - sync after address, held through transfer
// - write-byte flags output, or byte write
// - input handshake order, reply then release
// - output handshake order, reply then release
// - addressed slave replies to output strobe
// - block acknowledge while requesting interrupt
// - interrupt only when enable and request set
// - host acknowledges only when priority allows
// - on acknowledge reply with vector, then release
// - slave for commands, master for data
// - bus initialise clears all logic
module bpdma_dev
  import bpdma_pkg::*;
#(
  parameter logic [15:0] CSR_ADDR = `BPDMA_CSR_ADDR,
  parameter logic [15:0] VECTOR = `BPDMA_VECTOR,
  parameter int DEPTH = `BPDMA_FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic srst,
  bpdma_bus_if.dev bus,
  input wire logic tp_in_valid,
  output logic tp_in_ready,
  input wire logic [15:0] tp_in_data,
  output logic tp_out_valid,
  input wire logic tp_out_ready,
  output logic [15:0] tp_out_data,
  output logic run_o,
  output logic dir_o,
  output logic done_o
);
  typedef struct packed {
    bpdma_dev_st_t st;
    logic [15:0] addr;
    logic [15:0] cnt;
    logic run;
    logic dir;          // 1: tape read, store to memory
    logic ie;
    logic ireq;
    logic done;
    logic slv;          // slave cycle for us
    logic slv_rd;
    logic [15:0] dal;
    logic dal_oe_n;
    logic sync_oe_n, din_oe_n, dout_oe_n, wtbt_oe_n, bs7_oe_n, rply_oe_n;
    logic dmr_oe_n, sack_oe_n, irq_oe_n, dmgo_n, iako_n;
    logic [15:0] rdw;
    logic rdw_v;
  } bpdma_dev_s_t;
  bpdma_dev_s_t s_r, s_nxt;
  logic sync, din, dout, rply, dmgi, iaki, init;
  logic fo_valid, fo_ready, fi_valid, fi_ready;
  logic [15:0] fo_data;
  logic [15:0] cnt_dec;
  // asserted levels are low at the pins
  assign sync = !bus.sync_n;
  assign din = !bus.din_n;
  assign dout = !bus.dout_n;
  assign rply = !bus.rply_n;
  assign dmgi = !bus.dmgi_n;
  assign iaki = !bus.iaki_n;
  assign init = !bus.init_n;
  assign cnt_dec = s_r.cnt - 16'h0001;

  function automatic logic bank7(input logic [15:0] a);
    bank7 = (a >= `BPDMA_BANK7_BASE);
  endfunction

  // tape-read words queue here until a dma store can take them
  bpdma_fifo #(.W(16), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .srst(srst || init),
    .in_valid(fi_valid),
    .in_ready(fi_ready),
    .in_data(tp_in_data),
    .out_valid(fo_valid),
    .out_ready(fo_ready),
    .out_data(fo_data)
  );
  assign fi_valid = tp_in_valid && s_r.run && s_r.dir;
  assign fo_ready = (s_r.st == BD_SEND) && rply && s_r.dir;

  always_comb begin
    s_nxt = s_r;
    // grant and acknowledge chains pass unless we hold a request
    // a grant or acknowledge we captured is never passed on while we still use it
    s_nxt.dmgo_n = !(dmgi && s_r.dmr_oe_n && s_r.sack_oe_n && (s_r.st != BD_REQ));
    s_nxt.iako_n = !(iaki && !s_r.ireq && (s_r.st != BD_VEC));
    s_nxt.irq_oe_n = !(s_r.ie && s_r.ireq);
    if (s_r.rdw_v && tp_out_ready) begin
      s_nxt.rdw_v = 1'b0;
    end
    // slave side: command write and status read
    if (sync && !s_r.slv && s_r.sack_oe_n && bus.dal_n == ~CSR_ADDR && din == 1'b0 && dout == 1'b0) begin
      s_nxt.slv = 1'b1;
    end
    if (!sync) begin
      s_nxt.slv = 1'b0;
    end
    if (s_r.slv && dout && s_r.rply_oe_n && s_r.st != BD_VEC) begin
      s_nxt.run = ~bus.dal_n[0];          // latch command, then reply
      s_nxt.dir = ~bus.dal_n[1];
      s_nxt.ie = ~bus.dal_n[6];
      s_nxt.cnt = ~bus.dal_n[15:2] == 14'h0000 ? 16'h0001 : {2'b00, ~bus.dal_n[15:2]};
      s_nxt.done = 1'b0;
      s_nxt.addr = 16'h0000; // every command starts at word address 0
      s_nxt.rply_oe_n = 1'b0;
    end
    if (s_r.slv && din && s_r.rply_oe_n && s_r.st != BD_VEC) begin
      s_nxt.dal = {8'h00, s_r.done, s_r.ie, 4'h0, s_r.dir, s_r.run};
      s_nxt.dal_oe_n = 1'b0;
      s_nxt.rply_oe_n = 1'b0;
    end
    if (s_r.slv && !din && !dout && s_r.st != BD_VEC) begin
      s_nxt.rply_oe_n = 1'b1;
      s_nxt.dal_oe_n = 1'b1;
    end
    unique case (s_r.st)
      BD_IDLE: begin
        // interrupt acknowledge: strobe without sync
        if (din && !sync && iaki && s_r.ireq) begin
          s_nxt.ireq = 1'b0;
          s_nxt.dal = VECTOR;
          s_nxt.dal_oe_n = 1'b0;
          s_nxt.rply_oe_n = 1'b0;
          s_nxt.st = BD_VEC;
        end else if (s_r.run && !s_r.slv && (s_r.dir ? fo_valid : !s_r.rdw_v)) begin
          s_nxt.dmr_oe_n = 1'b0; // one request per word
          s_nxt.st = BD_REQ;
        end
      end
      BD_REQ: begin
        if (dmgi && !sync && !rply) begin
          s_nxt.sack_oe_n = 1'b0;
          s_nxt.dmr_oe_n = 1'b1;
          s_nxt.st = BD_ADDR;
        end
      end
      BD_ADDR: begin
        if (!dmgi) begin
          s_nxt.dal = s_r.addr; // address first
          s_nxt.dal_oe_n = 1'b0;
          s_nxt.bs7_oe_n = !bank7(s_r.addr);
          s_nxt.wtbt_oe_n = !s_r.dir; // word output announced
          s_nxt.st = BD_DATA;
        end
      end
      BD_DATA: begin
        s_nxt.sync_oe_n = 1'b0; // sync after address
        s_nxt.st = BD_SEND;
      end
      BD_SEND: begin
        // only a pure input or a pure output, never both
        s_nxt.bs7_oe_n = 1'b1;
        if (s_r.dir) begin
          s_nxt.dal = fo_data;
          s_nxt.wtbt_oe_n = 1'b1; // word write, not byte
          s_nxt.dout_oe_n = 1'b0;
          if (rply) begin
            s_nxt.dout_oe_n = 1'b1;
            s_nxt.dal_oe_n = 1'b1;
            s_nxt.st = BD_WREL;
          end
        end else begin
          s_nxt.dal_oe_n = 1'b1;
          s_nxt.wtbt_oe_n = 1'b1;
          s_nxt.din_oe_n = 1'b0;
          if (rply && !s_r.din_oe_n) begin
            s_nxt.rdw = ~bus.dal_n; // capture then drop strobe
            s_nxt.rdw_v = 1'b1;
            s_nxt.din_oe_n = 1'b1;
            s_nxt.st = BD_WREL;
          end
        end
      end
      BD_WREL: begin
        if (!rply) begin
          s_nxt.sync_oe_n = 1'b1;
          s_nxt.sack_oe_n = 1'b1; // hand bus back
          s_nxt.addr = s_r.addr + 16'h0002;
          s_nxt.cnt = cnt_dec;
          if (cnt_dec == 16'h0000) begin
            s_nxt.run = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.ireq = s_r.ie; // completion interrupt
          end
          s_nxt.st = BD_IDLE;
        end
      end
      BD_VEC: begin
        if (!din && !iaki) begin
          s_nxt.rply_oe_n = 1'b1;
          s_nxt.dal_oe_n = 1'b1;
          s_nxt.st = BD_IDLE;
        end
      end
    endcase
  end

  // init clears everything like reset, pending requests too
  always_ff @(posedge clk) begin
    if (srst || init) begin
      s_r <= '{st: BD_IDLE, addr: 16'h0000, cnt: 16'h0000, dal: 16'h0000, rdw: 16'h0000,
               dal_oe_n: 1'b1, sync_oe_n: 1'b1, din_oe_n: 1'b1, dout_oe_n: 1'b1, wtbt_oe_n: 1'b1,
               bs7_oe_n: 1'b1, rply_oe_n: 1'b1, dmr_oe_n: 1'b1, sack_oe_n: 1'b1, irq_oe_n: 1'b1,
               dmgo_n: 1'b1, iako_n: 1'b1, default: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.dal_dev_o = s_r.dal;
  assign bus.dal_dev_oe_n = s_r.dal_oe_n;
  assign bus.sync_dev_oe_n = s_r.sync_oe_n;
  assign bus.din_dev_oe_n = s_r.din_oe_n;
  assign bus.dout_dev_oe_n = s_r.dout_oe_n;
  assign bus.wtbt_dev_oe_n = s_r.wtbt_oe_n;
  assign bus.bs7_dev_oe_n = s_r.bs7_oe_n;
  assign bus.rply_dev_oe_n = s_r.rply_oe_n;
  assign bus.dmr_oe_n = s_r.dmr_oe_n;
  assign bus.sack_oe_n = s_r.sack_oe_n;
  assign bus.irq_oe_n = s_r.irq_oe_n;
  assign bus.dmgo_n = s_r.dmgo_n;
  assign bus.iako_n = s_r.iako_n;
  assign tp_in_ready = fi_ready && s_r.run && s_r.dir;
  assign tp_out_valid = s_r.rdw_v;
  assign tp_out_data = s_r.rdw;
  assign run_o = s_r.run;
  assign dir_o = s_r.dir;
  assign done_o = s_r.done;
endmodule
`default_nettype wire

/* hw/bpdma_host.sv */
// Purpose: host end: processor cycles, dma grant, interrupt acknowledge, small memory slave
// Assumes: bus pins synchronous to clk
// Notes: memory model is a small array of words, address bits wrap
`include "bpdma_map.svh"
`default_nettype none
module bpdma_host
  import bpdma_pkg::*;
#(
  parameter int MEM_WORDS = 64
) (
  input wire logic clk,
  input wire logic srst,
  bpdma_bus_if.host bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  input wire logic init_req,
  input wire logic prio_hi,
  output logic vec_valid,
  output logic [15:0] vec_data
);
  typedef struct packed {
    bpdma_host_st_t st;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wd;
    logic [15:0] dal;
    logic dal_oe_n, sync_oe_n, din_oe_n, dout_oe_n, wtbt_oe_n, bs7_oe_n, rply_oe_n;
    logic dmg_n, iak_n, init_n;
    logic rsp_v, vec_v;
    logic [15:0] rsp;
    logic [15:0] sl_addr;
    logic sl_act;
  } bpdma_host_s_t;
  localparam int MA = $clog2(MEM_WORDS);
  bpdma_host_s_t s_r, s_nxt;
  logic [15:0] mem [MEM_WORDS];
  logic mem_we;
  logic sack, dmr, irq, rply, sync, din, dout;
  assign sack = !bus.sack_n;
  assign dmr = !bus.dmr_n;
  assign irq = !bus.irq_n;
  assign rply = !bus.rply_n;
  assign sync = !bus.sync_n;
  assign din = !bus.din_n;
  assign dout = !bus.dout_n;
  assign cmd_ready = (s_r.st == BH_IDLE) && !dmr && !sack && !irq;
  assign mem_we = s_r.sl_act && dout && s_r.rply_oe_n;

  // memory write side of a dma output cycle
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[s_r.sl_addr[MA:1]] <= ~bus.dal_n;
    end
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_v = 1'b0;
    s_nxt.vec_v = 1'b0;
    s_nxt.init_n = !init_req;
    // grant only after our own cycle is over; drop when select-ack seen
    s_nxt.dmg_n = !(dmr && !sack && s_r.st == BH_IDLE && !sync);
    // memory slave for dma cycles
    if (sack && sync && !s_r.sl_act) begin
      s_nxt.sl_act = 1'b1;
      s_nxt.sl_addr = ~bus.dal_n;
    end
    if (s_r.sl_act && din && s_r.rply_oe_n) begin
      s_nxt.dal = mem[s_r.sl_addr[MA:1]];
      s_nxt.dal_oe_n = 1'b0;
      s_nxt.rply_oe_n = 1'b0;
    end
    if (mem_we) begin
      s_nxt.rply_oe_n = 1'b0;
    end
    if (s_r.sl_act && !din && !dout) begin
      s_nxt.rply_oe_n = 1'b1;
      s_nxt.dal_oe_n = 1'b1;
    end
    if (!sync) begin
      s_nxt.sl_act = 1'b0;
    end
    unique case (s_r.st)
      BH_IDLE: begin
        if (irq && !prio_hi && !sack) begin
          s_nxt.din_oe_n = 1'b0; // acknowledge only at low priority
          s_nxt.iak_n = 1'b0;
          s_nxt.st = BH_IACK;
        end else if (cmd_valid && cmd_ready) begin
          s_nxt.wr = cmd_write;
          s_nxt.addr = cmd_addr;
          s_nxt.wd = cmd_wdata;
          s_nxt.dal = cmd_addr;
          s_nxt.dal_oe_n = 1'b0;
          s_nxt.bs7_oe_n = !(cmd_addr >= `BPDMA_BANK7_BASE);
          s_nxt.wtbt_oe_n = !cmd_write;
          s_nxt.st = BH_ADDR;
        end
      end
      BH_ADDR: begin
        s_nxt.sync_oe_n = 1'b0;
        s_nxt.st = BH_STRB;
      end
      BH_STRB: begin
        s_nxt.bs7_oe_n = 1'b1;
        s_nxt.wtbt_oe_n = 1'b1;
        if (s_r.wr) begin
          s_nxt.dal = s_r.wd;
          s_nxt.dout_oe_n = 1'b0;
        end else begin
          s_nxt.dal_oe_n = 1'b1;
          s_nxt.din_oe_n = 1'b0;
        end
        if ((!s_r.dout_oe_n || !s_r.din_oe_n) && rply) begin
          s_nxt.rsp = ~bus.dal_n;
          s_nxt.dout_oe_n = 1'b1;
          s_nxt.din_oe_n = 1'b1;
          s_nxt.dal_oe_n = 1'b1;
          s_nxt.st = BH_REL;
        end
      end
      BH_REL: begin
        if (!rply) begin
          s_nxt.sync_oe_n = 1'b1;
          s_nxt.rsp_v = 1'b1;
          s_nxt.st = BH_END;
        end
      end
      BH_END: begin
        s_nxt.st = BH_IDLE;
      end
      BH_IACK: begin
        if (rply) begin
          s_nxt.rsp = ~bus.dal_n;
          s_nxt.vec_v = 1'b1;
          s_nxt.din_oe_n = 1'b1;
          s_nxt.iak_n = 1'b1;
          s_nxt.st = BH_REL;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_r <= '{st: BH_IDLE, addr: 16'h0000, wd: 16'h0000, dal: 16'h0000, rsp: 16'h0000, sl_addr: 16'h0000,
               dal_oe_n: 1'b1, sync_oe_n: 1'b1, din_oe_n: 1'b1, dout_oe_n: 1'b1, wtbt_oe_n: 1'b1,
               bs7_oe_n: 1'b1, rply_oe_n: 1'b1, dmg_n: 1'b1, iak_n: 1'b1, init_n: 1'b1, default: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign bus.dal_host_o = s_r.dal;
  assign bus.dal_host_oe_n = s_r.dal_oe_n;
  assign bus.sync_host_oe_n = s_r.sync_oe_n;
  assign bus.din_host_oe_n = s_r.din_oe_n;
  assign bus.dout_host_oe_n = s_r.dout_oe_n;
  assign bus.wtbt_host_oe_n = s_r.wtbt_oe_n;
  assign bus.bs7_host_oe_n = s_r.bs7_oe_n;
  assign bus.rply_host_oe_n = s_r.rply_oe_n;
  assign bus.dmgi_n = s_r.dmg_n;
  assign bus.iaki_n = s_r.iak_n;
  assign bus.init_n = s_r.init_n;
  assign rsp_valid = s_r.rsp_v;
  assign rsp_data = s_r.rsp;
  assign vec_valid = s_r.vec_v;
  assign vec_data = s_r.rsp;
endmodule
`default_nettype wire

/* verification/bpdma_sva.sv */
// Purpose: protocol checks on the joined backplane bus
// Assumes: resolved low-true pin levels, one clock domain
// Notes: chain outputs are registered, so blocking shows one cycle late
`default_nettype none
module bpdma_sva #(
  parameter logic [15:0] VECTOR = 16'h0070
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [15:0] dal_n,
  input wire logic sync_n,
  input wire logic din_n,
  input wire logic dout_n,
  input wire logic wtbt_n,
  input wire logic bs7_n,
  input wire logic rply_n,
  input wire logic dmr_n,
  input wire logic sack_n,
  input wire logic irq_n,
  input wire logic dmgi_n,
  input wire logic dmgo_n,
  input wire logic iako_n,
  input wire logic init_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [1:0] nsync_r;
  // sync assertions per bus tenure; no saturation needed, two already fails
  always_ff @(posedge clk) begin
    if (srst || sack_n) nsync_r <= 2'h0;
    else if ($fell(sync_n)) nsync_r <= nsync_r + 2'h1;
  end
  property p_grant; !dmr_n || !sack_n |=> dmgo_n; endproperty
  a_grant: assert property (p_grant) else $error("grant passed on while requesting");
  property p_sack; !dmr_n && !dmgi_n |-> ##[1:4] (!sack_n && dmr_n); endproperty
  a_sack: assert property (p_sack) else $error("no select ack after grant");
  property p_one; nsync_r < 2'h2; endproperty
  a_one: assert property (p_one) else $error("two transfers in one tenure");
  property p_rel; $rose(sync_n) && !$past(sack_n) |-> ##[0:4] sack_n; endproperty
  a_rel: assert property (p_rel) else $error("bus kept after transfer");
  property p_din; $fell(din_n) && !sync_n |-> ##[1:8] !rply_n; endproperty
  a_din: assert property (p_din) else $error("input strobe not answered");
  property p_dout; $fell(dout_n) && !sync_n |-> ##[1:8] !rply_n; endproperty
  a_dout: assert property (p_dout) else $error("output strobe not answered");
  property p_hold; !rply_n && !din_n |=> (!rply_n || din_n); endproperty
  a_hold: assert property (p_hold) else $error("reply dropped under input strobe");
  property p_sync; $rose(sync_n) |-> rply_n && din_n && dout_n; endproperty
  a_sync: assert property (p_sync) else $error("sync dropped mid transfer");
  property p_vec; sync_n && !din_n && !rply_n |-> (~dal_n) == VECTOR; endproperty
  a_vec: assert property (p_vec) else $error("wrong vector on acknowledge");
  property p_bank; $fell(sync_n) |-> bs7_n == ((~dal_n) < 16'hF000); endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong for address");
  property p_iack; !irq_n |=> iako_n; endproperty
  a_iack: assert property (p_iack) else $error("acknowledge passed while requesting");
  property p_init; !init_n [*3] |-> dmr_n && sack_n && irq_n; endproperty
  a_init: assert property (p_init) else $error("request survives bus init");
  // word writes only, so byte select never accompanies an output strobe
  property p_wtbt; !dout_n |-> wtbt_n; endproperty
  a_wtbt: assert property (p_wtbt) else $error("byte select during output strobe");
endmodule
`default_nettype wire

/* verification/bpdma_tb.sv */
// Purpose: self-checking bench for both bus ends joined by the carrier
// Assumes: inputs change 5 ns after the rising edge
// Notes: words stored by the store test are read back by the fetch test
`include "bpdma_map.svh"
`default_nettype none
module bpdma_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, srst, cmd_valid, cmd_ready, cmd_write, rsp_valid, init_req, prio_hi, vec_valid;
  logic tp_in_valid, tp_in_ready, tp_out_valid, tp_out_ready, run_o, dir_o, done_o;
  logic [15:0] cmd_addr, cmd_wdata, rsp_data, vec_data, tp_in_data, tp_out_data, rd;
  int n_mismatch = 0;
  int samples_checked = 0;
  bpdma_bus_if bus ();
  bpdma_dev i_bpdma_dev (.clk, .srst, .bus, .tp_in_valid, .tp_in_ready, .tp_in_data, .tp_out_valid,
    .tp_out_ready, .tp_out_data, .run_o, .dir_o, .done_o);
  bpdma_host i_bpdma_host (.clk, .srst, .bus, .cmd_valid, .cmd_ready, .cmd_write, .cmd_addr, .cmd_wdata,
    .rsp_valid, .rsp_data, .init_req, .prio_hi, .vec_valid, .vec_data);
  bpdma_sva #(.VECTOR(`BPDMA_VECTOR)) i_sva (.clk, .srst, .dal_n(bus.dal_n), .sync_n(bus.sync_n),
    .din_n(bus.din_n), .dout_n(bus.dout_n), .wtbt_n(bus.wtbt_n), .bs7_n(bus.bs7_n), .rply_n(bus.rply_n),
    .dmr_n(bus.dmr_n),
    .sack_n(bus.sack_n), .irq_n(bus.irq_n), .dmgi_n(bus.dmgi_n), .dmgo_n(bus.dmgo_n),
    .iako_n(bus.iako_n), .init_n(bus.init_n));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // inputs always move 5 ns after the edge, away from sampling
  task automatic tick();
    @(posedge clk);
    #5;
  endtask
  task automatic expire(input int k);
    if (k >= 3000) begin
      n_mismatch++;
      final_report();
    end
  endtask
  // one processor cycle, then the spacing the host end needs
  task automatic cyc(input logic w, input logic [15:0] a, input logic [15:0] d);
    int k;
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'h1;
    for (k = 0; k < 3000 && cmd_ready !== 1'h1; k++) tick();
    expire(k);
    tick();
    cmd_valid = 1'h0;
    for (k = 0; k < 3000 && rsp_valid !== 1'h1; k++) tick();
    expire(k);
    rd = rsp_data;
    repeat (5) tick();
  endtask
  task automatic wait_vec();
    int k;
    for (k = 0; k < 3000 && vec_valid !== 1'h1; k++) tick();
    expire(k);
    chk(vec_data, `BPDMA_VECTOR);
  endtask
  task automatic t_csr();
    cyc(1'h1, `BPDMA_CSR_ADDR, 16'h0042);
    cyc(1'h0, `BPDMA_CSR_ADDR, 16'h0000);
    chk(rd, 16'h0042);
    chk({14'h0000, dir_o, run_o}, 16'h0002);
    $display("t_csr done");
  endtask
  // 48 tape words pushed faster than the bus drains, so the fifo refuses
  task automatic t_store();
    int i, k;
    logic refused;
    refused = 1'h0;
    i = 0;
    cyc(1'h1, `BPDMA_CSR_ADDR, 16'h00C3);
    tp_in_valid = 1'h1;
    tp_in_data = 16'h5A00;
    for (k = 0; k < 3000 && i < 48; k++) begin
      if (tp_in_ready === 1'h1) i++;
      else refused = 1'h1;
      tick();
      tp_in_data = 16'h5A00 + 16'(i);
    end
    tp_in_valid = 1'h0;
    expire(k);
    chk({15'h0000, refused}, 16'h0001);
    wait_vec();
    cyc(1'h0, `BPDMA_CSR_ADDR, 16'h0000);
    chk(rd, 16'h00C2);
    $display("t_store done");
  endtask
  // tape side stalls every other cycle while memory words come back
  task automatic t_fetch();
    int i, k;
    i = 0;
    cyc(1'h1, `BPDMA_CSR_ADDR, 16'h00C1);
    for (k = 0; k < 3000 && i < 48; k++) begin
      tp_out_ready = k[0];
      if (tp_out_valid === 1'h1 && tp_out_ready === 1'h1) begin
        chk(tp_out_data, 16'h5A00 + 16'(i));
        i++;
      end
      tick();
    end
    tp_out_ready = 1'h1;
    expire(k);
    wait_vec();
    $display("t_fetch done");
  endtask
  // blocked acknowledge leaves the request up; bus init must clear it
  task automatic t_prio();
    int k;
    prio_hi = 1'h1;
    cyc(1'h1, `BPDMA_CSR_ADDR, 16'h0041);
    for (k = 0; k < 3000 && done_o !== 1'h1; k++) tick();
    expire(k);
    repeat (20) tick();
    chk({15'h0000, bus.irq_n}, 16'h0000);
    init_req = 1'h1;
    repeat (4) tick();
    init_req = 1'h0;
    tick();
    chk({13'h0000, bus.irq_n, run_o, done_o}, 16'h0004);
    prio_hi = 1'h0;
    $display("t_prio done");
  endtask
  initial begin
    srst = 1'h1;
    cmd_valid = 1'h0;
    cmd_write = 1'h0;
    cmd_addr = 16'h0000;
    cmd_wdata = 16'h0000;
    init_req = 1'h0;
    prio_hi = 1'h0;
    tp_in_valid = 1'h0;
    tp_in_data = 16'h0000;
    tp_out_ready = 1'h1;
    repeat (4) @(posedge clk);
    #5;
    srst = 1'h0;
    t_csr();
    t_store();
    t_fetch();
    t_prio();
    final_report();
  end
endmodule
`default_nettype wire
